// file: common/nfc_pkg.sv
// ============================================================
// Flash command controller constants
// Contract
// - Host puts unlock addresses 555H/2AAH (word) or AAAH/555H (byte).
// - Bits A11 to A19 are don't care except in program and sector cycles.
// - Program is AAH, 55H, A0H at first unlock, then location and value.
// - Erase is unlock, 80H, unlock, then 10H chip or 30H at sector.
// - Protect: reset pin high voltage, CE WE low, A6 low, A1 high, A0 low.
package nfc_pkg;
  // ============================================================
  // Widths
  localparam int ADR_W = 21;
  localparam int CNT_W = 16;
  // ============================================================
  // Register byte offsets on the Avalon slave
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_CFG = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  // Field positions and reset values
  localparam int CFG_BYTE_BIT = 0;
  localparam logic CFG_BYTE_RST = 1'b0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERASE = 1;
  localparam int STAT_SUSP = 2;
  localparam int STAT_REFUSED = 3;
  localparam int STAT_MODE_LSB = 4;
  // ============================================================
  // Unlock addresses in mode units (byte mode includes the lowest bit)
  localparam logic [ADR_W-1:0] UNL1_WORD = 21'h000555;
  localparam logic [ADR_W-1:0] UNL2_WORD = 21'h0002AA;
  localparam logic [ADR_W-1:0] UNL1_BYTE = 21'h000AAA;
  localparam logic [ADR_W-1:0] UNL2_BYTE = 21'h000555;
  // Command data values
  localparam logic [7:0] D_UNL1 = 8'hAA;
  localparam logic [7:0] D_UNL2 = 8'h55;
  localparam logic [7:0] D_ID = 8'h90;
  localparam logic [7:0] D_PROG = 8'hA0;
  localparam logic [7:0] D_ESETUP = 8'h80;
  localparam logic [7:0] D_CHIP = 8'h10;
  localparam logic [7:0] D_SECT = 8'h30;
  localparam logic [7:0] D_SUSP = 8'hB0;
  localparam logic [7:0] D_RESUME = 8'h30;
  localparam logic [7:0] D_RESET = 8'hF0;
  localparam logic [7:0] D_CFI = 8'h98;
  // ============================================================
  // Timing, all least times, rounded up to 4 ns cycles
  localparam int CLK_NS = 4;
  localparam int T_ACC_NS = 90;
  localparam int T_WP_NS = 30;
  localparam int T_WPH_NS = 30;
  localparam int T_RP_NS = 500;
  localparam int T_PROT_NS = 100000;
  localparam logic [CNT_W-1:0] CYC_ACC = CNT_W'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] CYC_WP = CNT_W'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] CYC_WPH = CNT_W'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] CYC_RP = CNT_W'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam int CYC_PROT = (T_PROT_NS + CLK_NS - 1) / CLK_NS;
  // ============================================================
  // Types
  typedef enum logic [3:0] {OP_NONE, OP_READ, OP_RESET, OP_ID, OP_PROG, OP_CERASE, OP_SERASE,
                            OP_SUSP, OP_RESUME, OP_CFI, OP_HWRST, OP_PROTECT, OP_UNPROTECT} nfc_op_t;
  typedef enum logic [1:0] {KIND_RD, KIND_WR, KIND_RST, KIND_HV} nfc_kind_t;
  typedef enum logic [1:0] {MODE_ARRAY, MODE_ID, MODE_CFI} nfc_mode_t;
endpackage

// file: design/nfc_ctrl.sv
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ns
// ============================================================
// Flash command controller: Avalon registers, command sequencer
module nfc_ctrl
  import nfc_pkg::*;
#(
  parameter int PROT_CYC = CYC_PROT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Flash pins
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  output logic fl_reset_n,
  output logic fl_hv_en,
  output logic fl_byte_n,
  output logic [19:0] fl_addr,
  input wire logic [15:0] fl_dq_in,
  output logic [15:0] fl_dq_out,
  output logic [15:0] fl_dq_oe
);
  typedef enum logic [1:0] {Q_IDLE, Q_ISSUE, Q_WAIT} nfc_seq_t;
  nfc_seq_t q_reg, q_next;
  nfc_op_t op_reg, op_next, cmd_op;
  nfc_mode_t mode_reg, mode_next;
  nfc_kind_t eng_kind_reg, eng_kind_next, tbl_kind;
  logic [2:0] step_reg, step_next;
  logic [ADR_W-1:0] addr_reg, addr_next, eng_addr_reg, eng_addr_next, tbl_addr, u1, u2, prot_addr;
  logic [15:0] data_reg, data_next, eng_wdata_reg, eng_wdata_next, tbl_data, rdata_reg, rdata_next, eng_rdata;
  logic [CNT_W-1:0] eng_len_reg, eng_len_next, tbl_len;
  logic byte_reg, byte_next, erase_reg, erase_next, susp_reg, susp_next, refused_reg, refused_next;
  logic eng_start_reg, eng_start_next, eng_done, tbl_last;
  logic wr_fire, cmd_go, cmd_bad;
  logic [31:0] rd_next, wmask;
  logic [7:0] sector;

  // ============================================================
  // Bus cycle engine
  nfc_cycle u_cycle (
    .mclk(mclk), .rst(rst),
    .start(eng_start_reg), .kind(eng_kind_reg), .addr(eng_addr_reg), .wdata(eng_wdata_reg),
    .byte_mode(byte_reg), .len(eng_len_reg),
    .done(eng_done), .rdata(eng_rdata),
    .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_reset_n(fl_reset_n),
    .fl_hv_en(fl_hv_en), .fl_byte_n(fl_byte_n), .fl_addr(fl_addr),
    .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe)
  );

  // ============================================================
  // Step table: address, data and kind of each bus cycle
  always_comb begin
    // Unlock pair depends on bus width; upper bits stay low
    u1 = byte_reg ? UNL1_BYTE : UNL1_WORD;
    u2 = byte_reg ? UNL2_BYTE : UNL2_WORD;
    // Sector on A19..A12, A6 picks protect or chip unprotect, A1 high, A0 low
    sector = byte_reg ? addr_reg[20:13] : addr_reg[19:12];
    prot_addr = {1'b0, sector, 5'h00, (op_reg == OP_UNPROTECT), 4'h0, 2'b10};
    if (byte_reg) begin
      prot_addr = {sector, 5'h00, (op_reg == OP_UNPROTECT), 4'h0, 2'b10, 1'b0};
    end
    tbl_kind = KIND_WR;
    tbl_len = CYC_WP;
    tbl_addr = u1;
    tbl_data = {8'h00, D_UNL1};
    tbl_last = 1'b0;
    // Unlock prefix shared by the multi-cycle sequences
    if (step_reg == 3'd1 || step_reg == 3'd4) begin
      tbl_addr = u2;
      tbl_data = {8'h00, D_UNL2};
    end
    unique case (op_reg)
      OP_READ: begin
        tbl_kind = KIND_RD;
        tbl_len = CYC_ACC;
        tbl_addr = addr_reg;
        tbl_last = 1'b1;
      end
      OP_ID: begin
        // Entry for identifier and protect verify reads
        if (step_reg == 3'd2) begin
          tbl_data = {8'h00, D_ID};
          tbl_last = 1'b1;
        end
      end
      OP_PROG: begin
        if (step_reg == 3'd2) begin
          tbl_data = {8'h00, D_PROG};
        end else if (step_reg == 3'd3) begin
          tbl_addr = addr_reg;
          tbl_data = data_reg;
          tbl_last = 1'b1;
        end
      end
      OP_CERASE, OP_SERASE: begin
        if (step_reg == 3'd2) begin
          tbl_data = {8'h00, D_ESETUP};
        end else if (step_reg == 3'd5) begin
          tbl_last = 1'b1;
          tbl_data = {8'h00, (op_reg == OP_CERASE) ? D_CHIP : D_SECT};
          if (op_reg == OP_SERASE) begin
            tbl_addr = addr_reg;
          end
        end
      end
      OP_RESET, OP_SUSP, OP_RESUME: begin
        // Single writes at a don't-care address
        tbl_addr = addr_reg;
        tbl_data = {8'h00, (op_reg == OP_RESET) ? D_RESET : ((op_reg == OP_SUSP) ? D_SUSP : D_RESUME)};
        tbl_last = 1'b1;
      end
      OP_CFI: begin
        tbl_data = {8'h00, D_CFI};
        tbl_last = 1'b1;
      end
      OP_HWRST: begin
        tbl_kind = KIND_RST;
        tbl_len = CYC_RP;
        tbl_last = 1'b1;
      end
      OP_PROTECT, OP_UNPROTECT: begin
        tbl_kind = KIND_HV;
        tbl_len = CNT_W'(PROT_CYC);
        tbl_addr = prot_addr;
        tbl_last = 1'b1;
      end
      default: begin
        tbl_last = 1'b1;
      end
    endcase
  end

  // ============================================================
  // Register access and sequencing
  always_comb begin
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wr_fire = avs_write && !avs_waitrequest;
    cmd_op = nfc_op_t'(avs_writedata[3:0]);
    // Suspend and resume only while a sector erase runs
    cmd_bad = (q_reg != Q_IDLE) || (avs_writedata[3:0] == 4'h0) || (avs_writedata[3:0] > 4'hC) ||
              ((cmd_op == OP_SUSP || cmd_op == OP_RESUME) && !erase_reg);
    cmd_go = wr_fire && (avs_address == REG_CMD) && avs_byteenable[0] && !cmd_bad;
    q_next = q_reg;
    op_next = op_reg;
    step_next = step_reg;
    mode_next = mode_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    byte_next = byte_reg;
    erase_next = erase_reg;
    susp_next = susp_reg;
    refused_next = refused_reg;
    rdata_next = rdata_reg;
    eng_start_next = 1'b0;
    eng_kind_next = eng_kind_reg;
    eng_addr_next = eng_addr_reg;
    eng_wdata_next = eng_wdata_reg;
    eng_len_next = eng_len_reg;
    if (wr_fire) begin
      unique case (avs_address)
        REG_ADDR: addr_next = ADR_W'((addr_reg & ~wmask[ADR_W-1:0]) | (avs_writedata[ADR_W-1:0] & wmask[ADR_W-1:0]));
        REG_DATA: data_next = (data_reg & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
        REG_CFG: begin
          if (q_reg == Q_IDLE && avs_byteenable[0]) begin
            byte_next = avs_writedata[CFG_BYTE_BIT];
          end
        end
        REG_STAT: begin
          if (avs_byteenable[0] && avs_writedata[STAT_ERASE]) begin
            erase_next = 1'b0;
            susp_next = 1'b0;
          end
        end
        REG_CMD: refused_next = !cmd_go;
        default: ;
      endcase
    end
    unique case (q_reg)
      Q_IDLE: begin
        if (cmd_go) begin
          op_next = cmd_op;
          step_next = 3'd0;
          q_next = Q_ISSUE;
        end
      end
      Q_ISSUE: begin
        eng_start_next = 1'b1;
        eng_kind_next = tbl_kind;
        eng_addr_next = tbl_addr;
        eng_wdata_next = tbl_data;
        eng_len_next = tbl_len;
        q_next = Q_WAIT;
      end
      Q_WAIT: begin
        if (eng_done) begin
          // Device acts only once the full sequence is out
          if (tbl_last) begin
            q_next = Q_IDLE;
            unique case (op_reg)
              OP_READ: rdata_next = eng_rdata;
              OP_ID: mode_next = MODE_ID;
              OP_CFI: mode_next = MODE_CFI;
              OP_SERASE: erase_next = 1'b1;
              OP_SUSP: susp_next = 1'b1;
              OP_RESUME: susp_next = 1'b0;
              OP_RESET, OP_HWRST: begin
                mode_next = MODE_ARRAY;
                erase_next = 1'b0;
                susp_next = 1'b0;
              end
              default: mode_next = MODE_ARRAY;
            endcase
          end else begin
            step_next = step_reg + 3'd1;
            q_next = Q_ISSUE;
          end
        end
      end
      default: q_next = Q_IDLE;
    endcase
    // Read data snapshot while waitrequest is still high
    unique case (avs_address)
      REG_ADDR: rd_next = {11'h000, addr_reg};
      REG_DATA: rd_next = {16'h0000, data_reg};
      REG_CFG: rd_next = {31'h00000000, byte_reg};
      REG_STAT: rd_next = {26'h0000000, mode_reg, refused_reg, susp_reg, erase_reg, (q_reg != Q_IDLE)};
      REG_RDATA: rd_next = {16'h0000, rdata_reg};
      default: rd_next = 32'h00000000;
    endcase
  end

  // Registers; one wait cycle on every access
  always_ff @(posedge mclk) begin
    if (rst) begin
      q_reg <= Q_IDLE;
      op_reg <= OP_NONE;
      step_reg <= 3'd0;
      mode_reg <= MODE_ARRAY;
      addr_reg <= '0;
      data_reg <= 16'h0000;
      byte_reg <= CFG_BYTE_RST;
      erase_reg <= 1'b0;
      susp_reg <= 1'b0;
      refused_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      eng_start_reg <= 1'b0;
      eng_kind_reg <= KIND_RD;
      eng_addr_reg <= '0;
      eng_wdata_reg <= 16'h0000;
      eng_len_reg <= CYC_WP;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      q_reg <= q_next;
      op_reg <= op_next;
      step_reg <= step_next;
      mode_reg <= mode_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      byte_reg <= byte_next;
      erase_reg <= erase_next;
      susp_reg <= susp_next;
      refused_reg <= refused_next;
      rdata_reg <= rdata_next;
      eng_start_reg <= eng_start_next;
      eng_kind_reg <= eng_kind_next;
      eng_addr_reg <= eng_addr_next;
      eng_wdata_reg <= eng_wdata_next;
      eng_len_reg <= eng_len_next;
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      avs_readdata <= rd_next;
    end
  end

  // ============================================================
  // Checks
  susp_gate_a: assert property (@(posedge mclk) disable iff (rst)
    cmd_go && (cmd_op == OP_SUSP || cmd_op == OP_RESUME) |-> erase_reg)
    else $error("Suspend or resume outside sector erase");
  unlock_first_a: assert property (@(posedge mclk) disable iff (rst)
    eng_start_reg && step_reg == 3'd0 && (op_reg inside {OP_ID, OP_PROG, OP_CERASE, OP_SERASE}) |->
    eng_addr_reg == (byte_reg ? UNL1_BYTE : UNL1_WORD) && eng_wdata_reg[7:0] == D_UNL1)
    else $error("First unlock cycle wrong");
  prog_fourth_a: assert property (@(posedge mclk) disable iff (rst)
    eng_start_reg && op_reg == OP_PROG && step_reg == 3'd3 |-> eng_addr_reg == addr_reg && eng_wdata_reg == data_reg)
    else $error("Program cycle carries wrong location or value");
  erase_sixth_a: assert property (@(posedge mclk) disable iff (rst)
    eng_start_reg && op_reg == OP_SERASE && step_reg == 3'd5 |-> eng_addr_reg == addr_reg && eng_wdata_reg[7:0] == D_SECT)
    else $error("Sector erase cycle wrong");
  hwrst_mode_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(fl_reset_n) |-> ##[1:12] (mode_reg == MODE_ARRAY && !erase_reg))
    else $error("Mode not back to array after hardware reset");
  protect_pins_a: assert property (@(posedge mclk) disable iff (rst)
    fl_hv_en && !fl_we_n |-> !fl_ce_n && fl_addr[1:0] == 2'b10 && fl_reset_n)
    else $error("Protect pulse pin pattern wrong");
  ack_one_a: assert property (@(posedge mclk) disable iff (rst) !avs_waitrequest |=> avs_waitrequest)
    else $error("Waitrequest low for more than one cycle");
endmodule

// file: design/nfc_cycle.sv
`timescale 1ns/1ns
// ============================================================
// One flash bus cycle: setup, strobe, recovery
module nfc_cycle
  import nfc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Request
  input wire logic start,
  input wire nfc_kind_t kind,
  input wire logic [ADR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic byte_mode,
  input wire logic [CNT_W-1:0] len,
  // Answer
  output logic done,
  output logic [15:0] rdata,
  // Flash pins
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  output logic fl_reset_n,
  output logic fl_hv_en,
  output logic fl_byte_n,
  output logic [19:0] fl_addr,
  input wire logic [15:0] fl_dq_in,
  output logic [15:0] fl_dq_out,
  output logic [15:0] fl_dq_oe
);
  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_RECOVER} nfc_cst_t;
  nfc_cst_t st_reg, st_next;
  nfc_kind_t kind_reg, kind_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic done_next, ce_n_next, oe_n_next, we_n_next, reset_n_next, hv_next, byte_n_next;
  logic [15:0] rdata_next, dq_out_next, dq_oe_next;
  logic [19:0] addr_next;
  logic is_wr;

  // ============================================================
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    kind_next = kind_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    rdata_next = rdata;
    ce_n_next = fl_ce_n;
    oe_n_next = fl_oe_n;
    we_n_next = fl_we_n;
    reset_n_next = fl_reset_n;
    hv_next = fl_hv_en;
    byte_n_next = fl_byte_n;
    addr_next = fl_addr;
    dq_out_next = fl_dq_out;
    dq_oe_next = fl_dq_oe;
    is_wr = (kind == KIND_WR) || (kind == KIND_HV);
    unique case (st_reg)
      S_IDLE: begin
        // Byte pin only moves between cycles, so width never changes mid-access
        byte_n_next = !byte_mode;
        if (start) begin
          kind_next = kind;
          cnt_next = len - CNT_W'(1);
          ce_n_next = (kind == KIND_RST);
          hv_next = (kind == KIND_HV);
          if (byte_mode) begin
            // Lowest address bit rides on data 15, upper data floats
            addr_next = addr[20:1];
            dq_out_next = {addr[0], 7'h00, wdata[7:0]};
            dq_oe_next = (kind == KIND_RST) ? 16'h0000 : (is_wr ? 16'h80FF : 16'h8000);
          end else begin
            addr_next = addr[19:0];
            dq_out_next = wdata;
            dq_oe_next = is_wr ? 16'hFFFF : 16'h0000;
          end
          st_next = S_SETUP;
        end
      end
      S_SETUP: begin
        // Read lowers OE only, writes lower WE only
        oe_n_next = (kind_reg != KIND_RD);
        we_n_next = !((kind_reg == KIND_WR) || (kind_reg == KIND_HV));
        reset_n_next = (kind_reg != KIND_RST);
        st_next = S_STROBE;
      end
      S_STROBE: begin
        if (cnt_reg == '0) begin
          if (kind_reg == KIND_RD) begin
            rdata_next = fl_byte_n ? fl_dq_in : {8'h00, fl_dq_in[7:0]};
          end
          oe_n_next = 1'b1;
          we_n_next = 1'b1;
          reset_n_next = 1'b1;
          cnt_next = CYC_WPH - CNT_W'(1);
          st_next = S_RECOVER;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      S_RECOVER: begin
        // Recovery also serves as the settle time after a reset pulse
        if (cnt_reg == '0) begin
          ce_n_next = 1'b1;
          hv_next = 1'b0;
          dq_oe_next = 16'h0000;
          done_next = 1'b1;
          st_next = S_IDLE;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
    endcase
  end

  // Registers; pins rest idle with reset released
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= S_IDLE;
      kind_reg <= KIND_RD;
      cnt_reg <= '0;
      done <= 1'b0;
      rdata <= 16'h0000;
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_reset_n <= 1'b1;
      fl_hv_en <= 1'b0;
      fl_byte_n <= 1'b1;
      fl_addr <= 20'h00000;
      fl_dq_out <= 16'h0000;
      fl_dq_oe <= 16'h0000;
    end else begin
      st_reg <= st_next;
      kind_reg <= kind_next;
      cnt_reg <= cnt_next;
      done <= done_next;
      rdata <= rdata_next;
      fl_ce_n <= ce_n_next;
      fl_oe_n <= oe_n_next;
      fl_we_n <= we_n_next;
      fl_reset_n <= reset_n_next;
      fl_hv_en <= hv_next;
      fl_byte_n <= byte_n_next;
      fl_addr <= addr_next;
      fl_dq_out <= dq_out_next;
      fl_dq_oe <= dq_oe_next;
    end
  end

  // ============================================================
  // Checks
  oe_we_excl_a: assert property (@(posedge mclk) disable iff (rst) !(!fl_oe_n && !fl_we_n))
    else $error("OE and WE low together");
  byte_upper_off_a: assert property (@(posedge mclk) disable iff (rst) !fl_byte_n |-> fl_dq_oe[14:8] == 7'h00)
    else $error("Upper data driven in byte mode");
  we_pulse_len_a: assert property (@(posedge mclk) disable iff (rst) $fell(fl_we_n) |-> !fl_we_n [*8])
    else $error("Write strobe too short");
  reset_quiet_a: assert property (@(posedge mclk) disable iff (rst) !fl_reset_n |-> fl_ce_n && fl_dq_oe == 16'h0000)
    else $error("Access during reset pulse");
endmodule

// file: tb/nfc_ctrl_tb_top.sv
`timescale 1ns/1ns
// ============================================================
// Bench for the flash command controller
module nfc_ctrl_tb_top
  import nfc_pkg::*;
();
  localparam logic [15:0] MAKER_ID = 16'h0011; // Arbitrary value
  localparam logic [15:0] PART_ID = 16'h0022; // Arbitrary value
  localparam logic [15:0] PRI [13] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0030, 16'h0000, 16'h0002,
                                       16'h0001, 16'h0001, 16'h0004, 16'h0000, 16'h0000, 16'h0000};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, s;
  logic avs_waitrequest, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, fl_hv_en, fl_byte_n;
  logic [19:0] fl_addr;
  logic [15:0] fl_dq_in, fl_dq_out;
  int n_mismatch = 0;
  int n_checks = 0;
  always #2 mclk = ~mclk;
  nfc_ctrl #(.PROT_CYC(20)) i_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .fl_reset_n(fl_reset_n), .fl_hv_en(fl_hv_en), .fl_byte_n(fl_byte_n), .fl_addr(fl_addr), .fl_dq_in(fl_dq_in),
    .fl_dq_out(fl_dq_out), .fl_dq_oe());
  nfc_flash_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) i_flash (.fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_reset_n(fl_reset_n), .fl_hv_en(fl_hv_en), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
    .fl_dq_in(fl_dq_in));
  // ============================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    s = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic op(input logic [3:0] c, input logic [20:0] a);
    bus(1'b1, REG_ADDR, {11'h0, a});
    bus(1'b1, REG_CMD, {28'h0, c});
    repeat (2) @(posedge mclk);
    do bus(1'b0, REG_STAT, 32'h0); while (s[STAT_BUSY] !== 1'b0);
  endtask
  task automatic rd_flash(input logic [20:0] a);
    op(4'h1, a);
    bus(1'b0, REG_RDATA, 32'h0);
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ============================================================
  // Scenarios
  task automatic t_reset;
    bus(1'b0, REG_STAT, 32'h0);
    chk(s, 32'h0);
    chk({31'h0, fl_ce_n}, 32'h1);
    bus(1'b0, 8'h40, 32'h0);
    chk(s, 32'h0);
    rd_flash(21'h00123);
    chk(s, {16'h0, 16'h0123 ^ 16'hC35A});
  endtask
  task automatic t_ident;
    op(4'h3, 21'h0);
    rd_flash(21'h0);
    chk(s, {16'h0, MAKER_ID});
    rd_flash(21'h1);
    chk(s, {16'h0, PART_ID});
    bus(1'b0, REG_STAT, 32'h0);
    chk(s & 32'h30, 32'h10);
    op(4'h2, 21'h0);
    rd_flash(21'h0);
    chk(s, 32'h0000C35A);
  endtask
  task automatic t_program;
    bus(1'b1, REG_DATA, 32'h0000BEEF);
    op(4'h4, 21'h00345);
    rd_flash(21'h00345);
    chk(s, 32'h0000BEEF);
  endtask
  task automatic t_query;
    op(4'h9, 21'h0);
    for (int i = 0; i < 13; i++) begin
      rd_flash(21'h40 + 21'(i));
      chk(s, {16'h0, PRI[i]});
    end
    op(4'h2, 21'h0);
  endtask
  task automatic t_erase;
    op(4'h7, 21'h0);
    bus(1'b0, REG_STAT, 32'h0);
    chk(s & 32'h0E, 32'h08);
    op(4'h6, 21'h10000);
    bus(1'b0, REG_STAT, 32'h0);
    chk(s & 32'h0E, 32'h02);
    op(4'h7, 21'h0);
    bus(1'b0, REG_STAT, 32'h0);
    chk(s & 32'h0E, 32'h06);
    op(4'h8, 21'h0);
    bus(1'b0, REG_STAT, 32'h0);
    chk(s & 32'h0E, 32'h02);
    op(4'hA, 21'h0);
    bus(1'b0, REG_STAT, 32'h0);
    chk(s & 32'h3E, 32'h0);
    op(4'h5, 21'h0);
    bus(1'b0, REG_STAT, 32'h0);
    chk(s & 32'h0E, 32'h0);
    op(4'h7, 21'h0);
    bus(1'b0, REG_STAT, 32'h0);
    chk(s & 32'h0E, 32'h08);
  endtask
  // Protect one sector, verify, then unprotect the chip
  task automatic t_protect;
    op(4'hB, 21'h5A000);
    op(4'h3, 21'h0);
    rd_flash(21'h5A002);
    chk(s, 32'h1);
    rd_flash(21'h00002);
    chk(s, 32'h0);
    op(4'hC, 21'h0);
    rd_flash(21'h5A002);
    chk(s, 32'h0);
    op(4'h2, 21'h0);
  endtask
  // Byte mode: address shifted onto A-1, upper data byte dropped
  task automatic t_bytes;
    bus(1'b1, REG_CFG, 32'h1);
    bus(1'b0, REG_CFG, 32'h0);
    chk(s, 32'h1);
    chk({31'h0, fl_byte_n}, 32'h0);
    rd_flash(21'h00247);
    chk(s, 32'h79);
    op(4'h3, 21'h0);
    rd_flash(21'h2);
    chk(s, {24'h0, PART_ID[7:0]});
    op(4'h2, 21'h0);
    bus(1'b1, REG_CFG, 32'h0);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_ident();
    t_program();
    t_query();
    t_protect();
    t_bytes();
    t_erase();
    report_and_stop();
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    report_and_stop();
  end
endmodule

// file: tb/nfc_flash_model.sv
`timescale 1ns/1ns
// ============================================================
// Behavioural flash device, word mode command decoder
module nfc_flash_model #(
  parameter logic [15:0] MAKER_ID = 16'h0011, // Arbitrary value
  parameter logic [15:0] PART_ID = 16'h0022 // Arbitrary value
) (
  // Strobes and reset pin
  input wire logic fl_ce_n,
  input wire logic fl_oe_n,
  input wire logic fl_we_n,
  input wire logic fl_reset_n,
  input wire logic fl_hv_en,
  // Address and data
  input wire logic [19:0] fl_addr,
  input wire logic [15:0] fl_dq_out,
  output logic [15:0] fl_dq_in
);
  localparam logic [15:0] PRI [13] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0030, 16'h0000, 16'h0002,
                                       16'h0001, 16'h0001, 16'h0004, 16'h0000, 16'h0000, 16'h0000};
  logic [2:0] step = 3'h0;
  logic [1:0] mode = 2'h0; // Array read from power-up
  logic erasing = 1'b0;
  logic susp = 1'b0;
  logic [19:0] pl = 20'hFFFFF;
  logic [15:0] pv = 16'h0000;
  logic [255:0] prot = '0; // One flag per sector, all unprotected at power-up
  logic [15:0] rv;
  wire logic [10:0] a = fl_addr[10:0]; // Upper bits ignored
  wire logic [7:0] d = fl_dq_out[7:0];
  // Command register, taken on the rising write strobe
  always @(posedge fl_we_n or negedge fl_reset_n) begin
    if (!fl_reset_n) begin
      step = 3'h0;
      mode = 2'h0;
      erasing = 1'b0;
      susp = 1'b0;
    end else if (fl_hv_en) begin
      // High voltage write: no command decode, only protection changes
      if (fl_addr[1:0] == 2'b10 && fl_addr[6]) prot = '0;
      else if (fl_addr[1:0] == 2'b10) prot[fl_addr[19:12]] = 1'b1;
    end else if (!fl_ce_n && fl_oe_n) begin
      if (d == 8'hF0) begin
        step = 3'h0;
        mode = 2'h0;
      end else begin
        case (step)
          3'h0: begin
            susp = erasing && (d == 8'hB0 || (susp && d != 8'h30));
            if (a == 11'h555 && d == 8'h98) mode = 2'h2;
            step = (a == 11'h555 && d == 8'hAA) ? 3'h1 : 3'h0;
          end
          3'h1: step = (a == 11'h2AA && d == 8'h55) ? 3'h2 : 3'h0;
          3'h2: begin
            if (a == 11'h555 && d == 8'h90) mode = 2'h1;
            step = (a != 11'h555) ? 3'h0 : (d == 8'hA0) ? 3'h3 : (d == 8'h80) ? 3'h4 : 3'h0;
          end
          3'h3: begin
            pl = fl_addr;
            pv = fl_dq_out;
            step = 3'h0;
          end
          3'h4: step = (a == 11'h555 && d == 8'hAA) ? 3'h5 : 3'h0;
          3'h5: step = (a == 11'h2AA && d == 8'h55) ? 3'h6 : 3'h0;
          default: begin
            erasing = (d == 8'h30);
            step = 3'h0;
          end
        endcase
      end
    end
  end
  // Read data: identifier, query table or array
  always_comb begin
    if (mode == 2'h1) rv = fl_addr[1] ? {15'h0000, prot[fl_addr[19:12]]} : (fl_addr[0] ? PART_ID : MAKER_ID);
    else if (mode == 2'h2 && fl_addr[7:4] == 4'h4 && fl_addr[3:0] < 4'hD) rv = PRI[fl_addr[3:0]];
    else rv = (fl_addr == pl) ? pv : fl_addr[15:0] ^ 16'hC35A;
  end
  // Released bus shows the inverse, never a stale value
  assign fl_dq_in = (!fl_ce_n && !fl_oe_n && fl_we_n && fl_reset_n) ? rv : ~rv;
endmodule
